// ### design/panel_key_scan_display_latch.sv
// Function
// RULE_01: a column number on the four address lines energizes that column.
// RULE_02: the controller strobes keys only once the column number is stable.
// RULE_03: while the key strobe is held the row latch follows the row lines.
// RULE_04: the controller then treats any set row bit as a pressed key.
// RULE_05: eight addressable latches drive two hex digits and three lamps.
// RULE_06: a latch loads new data only on the display write strobe.
// RULE_07: the latch address is held in its own register until the write.
// RULE_08: a write strobes in the address, then sets data, then pulses write.
// RULE_09: about 100 ms after power-up all display latches are cleared.
// RULE_10: one display latch is the enable of the bell tone generator.
// RULE_11: the controller releases the key strobe before a new address.
`default_nettype none
module panel_key_scan_display_latch
   import panel_pkg::*;
#(
   parameter int POWERUP_COUNT = POWERUP_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // panel controller pins
   input wire logic [COL_ADDR_W-1:0] panel_address_lines,
   input wire logic key_strobe_n,
   input wire logic display_write_strobe_n,
   output logic [ROW_WIDTH-1:0] key_row_data_lines,
   // key matrix
   output logic [NUM_COLUMNS-1:0] column_drive,
   input wire logic [ROW_WIDTH-1:0] key_rows,
   // display and tone
   output logic [NUM_LATCHES-1:0] display_latches,
   output logic tone_enable_latch,
   output logic latches_ready
);
   ////////////////////////////////////////////////////////////////////////
   logic [COL_ADDR_W-1:0] addr_s;
   logic kstb_s;
   logic kwr_s;
   logic [ROW_WIDTH-1:0] rows_s;
   logic kwr_d;
   logic write_pulse;
   logic [LATCH_ADDR_W-1:0] latch_address_holding_register;
   pwr_state_t pwr_state;
   logic [31:0] pwr_count;

   pin_sync #(.W(COL_ADDR_W + 2 + ROW_WIDTH)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({panel_address_lines, ~key_strobe_n,
                 ~display_write_strobe_n, key_rows}),
      .sync_out({addr_s, kstb_s, kwr_s, rows_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // column decode, one-hot
   always_ff @(posedge core_clk) begin
      if (rst) begin
         column_drive <= '0;
      end else begin
         column_drive <= NUM_COLUMNS'(1) << addr_s; // [RULE_01]
      end
   end

   // row latch transparent while strobe held
   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_row_data_lines <= '0;
      end else if (kstb_s) begin
         key_row_data_lines <= rows_s; // [RULE_03] [RULE_04]
      end
   end

   // latch address captured on the key strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         latch_address_holding_register <= '0;
      end else if (kstb_s) begin
         latch_address_holding_register <=
            addr_s[LATCH_ADDR_W-1:0]; // [RULE_07]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write strobe edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         kwr_d <= 1'b0;
      end else begin
         kwr_d <= kwr_s;
      end
   end
   assign write_pulse = kwr_s & ~kwr_d;

   // power-up delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwr_state <= PWR_WAIT;
         pwr_count <= '0;
      end else begin
         case (pwr_state)
            PWR_WAIT: begin
               if (pwr_count >= 32'(POWERUP_COUNT - 1)) begin
                  pwr_state <= PWR_RUN; // [RULE_09]
               end else begin
                  pwr_count <= pwr_count + 32'd1;
               end
            end
            PWR_RUN: begin
               pwr_state <= PWR_RUN;
            end
            default: begin
               pwr_state <= PWR_WAIT;
            end
         endcase
      end
   end
   assign latches_ready = (pwr_state == PWR_RUN);

   // addressable latches
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LATCHES; gi++) begin : g_latch
         always_ff @(posedge core_clk) begin
            if (rst) begin
               display_latches[gi] <= LATCH_RESET_VALUE[gi];
            end else if (pwr_state != PWR_RUN) begin
               display_latches[gi] <= LATCH_RESET_VALUE[gi]; // [RULE_09]
            end else if (write_pulse &&
                         latch_address_holding_register ==
                         LATCH_ADDR_W'(gi)) begin
               display_latches[gi] <= addr_s[DATA_BIT]; // [RULE_05] [RULE_06]
            end
         end
      end
   endgenerate

   assign tone_enable_latch = display_latches[LATCH_TONE]; // [RULE_10]

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [31:0] chk_wait;

   // cycles spent waiting for the latches since reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         chk_wait <= '0;
      end else if (!latches_ready) begin
         chk_wait <= chk_wait + 32'd1;
      end
   end

   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // write strobe edge while the latches run
   sequence s_write;
      kwr_s && !kwr_d && latches_ready;
   endsequence

   // write strobe still held one edge after its edge
   sequence s_write_held;
      s_write ##1 kwr_s;
   endsequence

   // key strobe released after being held
   sequence s_strobe_end;
      kstb_s ##1 !kstb_s;
   endsequence

   // power-up wait just over
   sequence s_ready_rise;
      !latches_ready ##1 latches_ready;
   endsequence

   AST_COLUMN_ONEHOT: assert property ( // [RULE_01]
      1'b1 |=> column_drive == (NUM_COLUMNS'(1) << $past(addr_s)))
      else $error("column drive not matching address");

   AST_COLUMN_SINGLE: assert property ( // [RULE_01]
      1'b1 |=> $onehot(column_drive))
      else $error("not exactly one column energized");

   AST_ROW_FOLLOWS: assert property ( // [RULE_03]
      kstb_s |=> key_row_data_lines == $past(rows_s))
      else $error("row latch not following rows under strobe");

   AST_ROW_HOLDS: assert property ( // [RULE_03]
      !kstb_s |=> $stable(key_row_data_lines))
      else $error("row latch changed without strobe");

   AST_ROW_KEEPS_LAST: assert property ( // [RULE_03]
      s_strobe_end |=> key_row_data_lines == $past(rows_s, 2))
      else $error("row latch lost the last strobed pattern");

   AST_ADDR_CAPTURE: assert property ( // [RULE_07]
      kstb_s |=> latch_address_holding_register ==
         $past(addr_s[LATCH_ADDR_W-1:0]))
      else $error("latch address not taken under strobe");

   AST_ADDR_HOLDS: assert property ( // [RULE_07]
      !kstb_s |=> $stable(latch_address_holding_register))
      else $error("held latch address changed without strobe");

   AST_NO_WRITE_NO_CHANGE: assert property ( // [RULE_06]
      latches_ready && !write_pulse |=> $stable(display_latches))
      else $error("display latch changed without write strobe");

   AST_ONE_LOAD_PER_PULSE: assert property ( // [RULE_06]
      s_write_held |=> $stable(display_latches))
      else $error("held write strobe loaded again");

   AST_WRITE_LOADS: assert property ( // [RULE_05]
      s_write |=> display_latches[$past(latch_address_holding_register)]
         == $past(addr_s[DATA_BIT]))
      else $error("selected latch did not load data");

   AST_WRITE_ONLY_ONE: assert property ( // [RULE_05]
      s_write |=> ((display_latches ^ $past(display_latches)) &
         ~(NUM_LATCHES'(1) << $past(latch_address_holding_register))) == '0)
      else $error("write changed an unselected latch");

   AST_CLEAR_BEFORE_READY: assert property ( // [RULE_09]
      !latches_ready |-> display_latches == LATCH_RESET_VALUE)
      else $error("latches not clear during power-up delay");

   AST_READY_DELAY: assert property ( // [RULE_09]
      s_ready_rise |-> chk_wait == 32'(POWERUP_COUNT))
      else $error("power-up delay not of the set length");

   AST_TONE_IS_LATCH: assert property ( // [RULE_10]
      s_write and (latch_address_holding_register == LATCH_TONE)
      |=> tone_enable_latch == $past(addr_s[DATA_BIT]))
      else $error("tone enable not following its latch write");

endmodule : panel_key_scan_display_latch
`default_nettype wire

// ### design/panel_pkg.sv
`default_nettype none
package panel_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int POWERUP_DELAY_MS = 100;
   localparam int POWERUP_CYCLES = CLK_HZ / 1000 * POWERUP_DELAY_MS;
   localparam int NUM_LATCHES = 8;
   localparam int NUM_COLUMNS = 16;
   localparam int ROW_WIDTH = 8;
   localparam int LATCH_ADDR_W = 3;
   localparam int COL_ADDR_W = 4;
   // latch map
   localparam logic [2:0] LATCH_DIGIT0_A = 3'h0;
   localparam logic [2:0] LATCH_DIGIT0_B = 3'h1;
   localparam logic [2:0] LATCH_DIGIT1_A = 3'h2;
   localparam logic [2:0] LATCH_DIGIT1_B = 3'h3;
   localparam logic [2:0] LATCH_LAMP0 = 3'h4;
   localparam logic [2:0] LATCH_LAMP1 = 3'h5;
   localparam logic [2:0] LATCH_LAMP2 = 3'h6;
   localparam logic [2:0] LATCH_TONE = 3'h7;
   localparam logic [7:0] LATCH_RESET_VALUE = 8'h00;
   // data bit position on the shared lines
   localparam int DATA_BIT = 0;
   localparam int SPARE_BIT = 1;
   typedef enum {
      PWR_WAIT,
      PWR_RUN
   } pwr_state_t;
endpackage : panel_pkg
`default_nettype wire

// ### design/pin_sync.sv
`default_nettype none
module pin_sync
   import panel_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ### dv/panel_ctrl_model.sv
`default_nettype none
module panel_ctrl_model
   import panel_pkg::*;
(
   // clock
   input wire logic core_clk,
   // panel pins
   output logic [COL_ADDR_W-1:0] panel_address_lines,
   output logic key_strobe_n,
   output logic display_write_strobe_n,
   input wire logic [ROW_WIDTH-1:0] key_row_data_lines,
   // key matrix
   input wire logic [NUM_COLUMNS-1:0] column_drive,
   output logic [ROW_WIDTH-1:0] key_rows
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [ROW_WIDTH-1:0] pressed [NUM_COLUMNS];
   initial begin
      panel_address_lines = '0;
      key_strobe_n = 1'b1;
      display_write_strobe_n = 1'b1;
      foreach (pressed[c]) pressed[c] = '0;
   end
   // rows show the keys of every energized column
   always_comb begin
      key_rows = '0;
      for (int c = 0; c < NUM_COLUMNS; c++) begin
         if (column_drive[c] === 1'b1) key_rows = key_rows | pressed[c];
      end
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask : hold
   task automatic scan(input logic [3:0] col, output logic [7:0] rows);
      panel_address_lines = col;
      hold(4);
      key_strobe_n = 1'b0;
      hold(5);
      rows = key_row_data_lines;
      key_strobe_n = 1'b1;
      hold(4);
   endtask : scan
   task automatic write(input logic [2:0] adr, input logic d);
      panel_address_lines = {1'b0, adr};
      hold(4);
      key_strobe_n = 1'b0;
      hold(4);
      key_strobe_n = 1'b1;
      hold(4);
      panel_address_lines = {3'h0, d};
      hold(4);
      display_write_strobe_n = 1'b0;
      hold(4);
      display_write_strobe_n = 1'b1;
      hold(4);
   endtask : write
endmodule : panel_ctrl_model
`default_nettype wire

// ### dv/panel_key_scan_display_latch_bench.sv
`default_nettype none
module panel_key_scan_display_latch_bench
   import panel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, key_strobe_n, display_write_strobe_n, tone_enable_latch;
   logic latches_ready;
   logic [3:0] panel_address_lines;
   logic [7:0] key_row_data_lines, key_rows, display_latches, exp_lat, rows;
   logic [15:0] column_drive, lfsr;
   logic [7:0] keys [16];
   int bad_count = 0;
   int compares = 0;
   int waited;
   localparam int WAIT_CYCLES = 20;
   panel_key_scan_display_latch #(.POWERUP_COUNT(WAIT_CYCLES)) dut (
      .core_clk(core_clk),
      .rst(rst), .panel_address_lines(panel_address_lines),
      .key_strobe_n(key_strobe_n),
      .display_write_strobe_n(display_write_strobe_n),
      .key_row_data_lines(key_row_data_lines), .column_drive(column_drive),
      .key_rows(key_rows), .display_latches(display_latches),
      .tone_enable_latch(tone_enable_latch), .latches_ready(latches_ready));
   panel_ctrl_model pm (.core_clk(core_clk),
      .panel_address_lines(panel_address_lines), .key_strobe_n(key_strobe_n),
      .display_write_strobe_n(display_write_strobe_n),
      .key_row_data_lines(key_row_data_lines), .column_drive(column_drive),
      .key_rows(key_rows));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   function automatic logic [15:0] col_onehot(input logic [3:0] c);
      return 16'h0001 << c;
   endfunction : col_onehot
   task automatic check(input logic [15:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h",
                  $time, what, got, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task automatic wait_ready(output int cycles);
      cycles = 0;
      while (cycles < 100 && latches_ready !== 1'b1) begin
         pm.hold(1);
         cycles++;
      end
      check({15'h0, latches_ready}, 16'h1, "ready");
   endtask : wait_ready
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      #(100 * 20000);
      bad_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      lfsr = 16'h7aea;
      exp_lat = '0;
      repeat (4) @(posedge core_clk);
      #10 rst = 1'b0;
      pm.write(3'h7, 1'b1);
      check({8'h0, display_latches}, 16'h0, "early write");
      wait_ready(waited);
      for (int i = 0; i < 17; i++) begin
         lfsr = lfsr_next(lfsr);
         exp_lat[i[2:0]] = (i < 8) ? 1'b1 : (i < 16) ? lfsr[0] : 1'b0;
         pm.write(i[2:0], exp_lat[i[2:0]]);
         check({8'h0, display_latches}, {8'h0, exp_lat},
               "latch");
         check({15'h0, tone_enable_latch}, {15'h0, exp_lat[7]},
               "tone");
      end
      $display("latch write test done");
      for (int c = 0; c < 16; c++) begin
         lfsr = lfsr_next(lfsr);
         keys[c] = (c == 0) ? 8'h00 : (c == 15) ? 8'hff : lfsr[7:0];
         pm.pressed[c] = keys[c];
      end
      for (int c = 0; c < 16; c++) begin
         pm.scan(c[3:0], rows);
         check(column_drive, col_onehot(c[3:0]), "column");
         check({8'h0, rows}, {8'h0, keys[c]}, "rows");
      end
      check({8'h0, display_latches}, {8'h0, exp_lat},
            "latch hold");
      $display("key scan test done");
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #10 rst = 1'b0;
      check({7'h0, latches_ready, display_latches}, 16'h0,
            "reset");
      wait_ready(waited);
      check(16'(waited), 16'(WAIT_CYCLES), "delay");
      check({8'h0, display_latches}, 16'h0, "cleared");
      $display("reset test done");
      complete_run();
   end
endmodule : panel_key_scan_display_latch_bench
`default_nettype wire
